// ---- inc/flash_status_pkg.sv ----
// Package of constants and types for the flash write-status polling controller
package flash_status_pkg;

   // ----------------------------------------------------------------
   // Status bit positions on the data bus, and bus widths
   // ----------------------------------------------------------------
   localparam int POLL_BIT_POS = 7;     // inverted_data_poll_bit
   localparam int TOGGLE_ONE_POS = 6;   // toggle_bit_one
   localparam int LIMIT_FLAG_POS = 5;   // timing_limit_flag
   localparam int TOGGLE_TWO_POS = 2;   // toggle_bit_two
   localparam int DATA_WIDTH = 16;      // flash data bus width
   localparam int ADDR_WIDTH = 21;      // flash word address width

   // ----------------------------------------------------------------
   // Bus timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;          // 200 MHz clock
   localparam int READ_ACCESS_NS = 85;           // least read access time
   localparam int WRITE_PULSE_NS = 35;           // least write strobe low time
   localparam int STROBE_HIGH_NS = 30;           // least strobe high time between cycles
   localparam int READ_CYCLES = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WRITE_CYCLES = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HIGH_CYCLES = (STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TIMER_WIDTH = 8;               // width of the strobe phase timer

   // ----------------------------------------------------------------
   // Reset command and result codes
   // ----------------------------------------------------------------
   localparam logic [DATA_WIDTH-1:0] RESET_COMMAND = 16'h00f0;
   localparam logic [1:0] RESULT_DONE = 2'h0;     // finished cleanly
   localparam logic [1:0] RESULT_FAILED = 2'h1;   // limit flag and still busy
   localparam logic [1:0] RESULT_ABORTED = 2'h2;  // host gave up polling

   // Polling method
   typedef enum logic {
      METHOD_TOGGLE,
      METHOD_POLL
   } method_type;

   // Single bus cycle kind
   typedef enum logic {
      CYCLE_READ,
      CYCLE_WRITE
   } cycle_type;

endpackage : flash_status_pkg

// ---- verilog/flash_bus_cycle.sv ----
// Single asynchronous flash bus read or write cycle generator
`timescale 1ns/1ps
`default_nettype none

module flash_bus_cycle
   import flash_status_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Request side
   input wire logic start,
   input wire flash_status_pkg::cycle_type kind,
   input wire logic [flash_status_pkg::ADDR_WIDTH-1:0] addr,
   input wire logic [flash_status_pkg::DATA_WIDTH-1:0] wdata,
   output logic done,
   output logic [flash_status_pkg::DATA_WIDTH-1:0] rdata,
   // Flash pins
   output logic chip_sel_n,
   output logic out_en_n,
   output logic write_en_n,
   output logic [flash_status_pkg::ADDR_WIDTH-1:0] addr_pin,
   output logic [flash_status_pkg::DATA_WIDTH-1:0] data_out,
   output logic data_oe_n,
   input wire logic [flash_status_pkg::DATA_WIDTH-1:0] data_sync
);

   // ----------------------------------------------------------------
   // Cycle sequencer
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ACTIVE,
      PH_RECOVER
   } phase_type;

   phase_type phase, next_phase;                  // strobe phase
   logic [TIMER_WIDTH-1:0] timer, next_timer;     // phase countdown
   logic is_read, next_is_read;                   // current cycle is a read
   logic [DATA_WIDTH-1:0] next_rdata;             // captured read data
   logic [ADDR_WIDTH-1:0] next_addr_pin;          // held address
   logic [DATA_WIDTH-1:0] next_data_out;          // held write data
   logic next_done;                               // end-of-cycle pulse

   // Next-state logic; data input already synchronised, so the read
   // window is stretched by two cycles to cover that delay
   always_comb begin
      next_phase = phase;
      next_timer = timer;
      next_is_read = is_read;
      next_rdata = rdata;
      next_addr_pin = addr_pin;
      next_data_out = data_out;
      next_done = 1'b0;
      unique case (phase)
         PH_IDLE: begin
            if (start) begin
               next_phase = PH_ACTIVE;
               next_is_read = (kind == CYCLE_READ);
               next_addr_pin = addr;
               next_data_out = wdata;
               next_timer = (kind == CYCLE_READ) ? TIMER_WIDTH'(READ_CYCLES + 2)
                                                 : TIMER_WIDTH'(WRITE_CYCLES);
            end
         end
         PH_ACTIVE: begin
            if (timer == '0) begin
               // Sample at the end of the strobe, just before release
               if (is_read) begin
                  next_rdata = data_sync;
               end
               next_phase = PH_RECOVER;
               next_timer = TIMER_WIDTH'(HIGH_CYCLES);
            end else begin
               next_timer = timer - 1'b1;
            end
         end
         PH_RECOVER: begin
            if (timer == '0) begin
               next_phase = PH_IDLE;
               next_done = 1'b1;
            end else begin
               next_timer = timer - 1'b1;
            end
         end
         default: begin
            next_phase = PH_IDLE;
         end
      endcase
   end

   // Registers only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase <= PH_IDLE;
         timer <= '0;
         is_read <= 1'b0;
         rdata <= '0;
         addr_pin <= '0;
         data_out <= '0;
         done <= 1'b0;
      end else begin
         phase <= next_phase;
         timer <= next_timer;
         is_read <= next_is_read;
         rdata <= next_rdata;
         addr_pin <= next_addr_pin;
         data_out <= next_data_out;
         done <= next_done;
      end
   end

   // Strobes follow the phase; each read strobe is a fresh read cycle
   assign chip_sel_n = (phase != PH_ACTIVE);
   assign out_en_n = !((phase == PH_ACTIVE) && is_read);
   assign write_en_n = !((phase == PH_ACTIVE) && !is_read);
   // Bus driven only during and just after a write; low enable means driving
   assign data_oe_n = !((phase != PH_IDLE) && !is_read);

endmodule : flash_bus_cycle

`default_nettype wire

// ---- verilog/flash_status_poller.sv ----
// Host-side controller that polls flash write-operation status bits
// Function
// [R1] Poll bit inverted while programming, true after
// [R2] Status valid after last write strobe
// [R3] Program polling reads at the program address
// [R4] Protected program: ~1 us status then array
// [R5] Erase polling bit zero, one when done
// [R6] Erase polling reads inside an erasing sector
// [R7] All-protected erase: ~100 us status then array
// [R8] Partly protected erase skips protected sectors
// [R9] Poll bit may lead data; reread
// [R10] Busy pin low while programming or erasing
// [R11] Toggle bit one flips each busy read
// [R12] Toggle bit one valid from final strobe
// [R13] All-protected erase toggles ~100 us
// [R14] Protected program toggles ~1 us
// [R15] Toggling stops in erase suspend
// [R16] Toggle bit two flips in erase sectors
// [R17] Two reads, compare toggle bit
// [R18] Toggling with limit flag: recheck, reset
// [R19] Resumed polling restarts with double read
// [R20] Reread poll bit after limit flag
// [R21] Limit flag set when pulse count exceeded
// [R22] Status kept per bank
`timescale 1ns/1ps
`default_nettype none

module flash_status_poller
   import flash_status_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // User command
   input wire logic START,
   input wire logic ABORT,
   input wire flash_status_pkg::method_type METHOD,
   input wire logic [flash_status_pkg::ADDR_WIDTH-1:0] STATUS_ADDR,
   input wire logic [flash_status_pkg::DATA_WIDTH-1:0] EXPECT_DATA,
   input wire logic ERASE_OP,
   // User answer
   output logic BUSY,
   output logic DONE,
   output logic [1:0] RESULT,
   output logic [flash_status_pkg::DATA_WIDTH-1:0] FINAL_DATA,
   output logic SECTOR_ERASING,
   output logic JOB_ACTIVE,
   // Flash bus pins
   output logic CHIP_SEL_N,
   output logic OUT_EN_N,
   output logic WRITE_EN_N,
   output logic [flash_status_pkg::ADDR_WIDTH-1:0] ADDR,
   output logic [flash_status_pkg::DATA_WIDTH-1:0] DATA_OUT,
   output logic DATA_OE_N,
   input wire logic [flash_status_pkg::DATA_WIDTH-1:0] DATA_IN,
   // Open-drain busy pin from the flash
   input wire logic JOB_ACTIVE_LOW_PIN
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [DATA_WIDTH-1:0] data_meta, data_sync;   // data bus stages
   logic busy_meta, busy_sync;                    // busy pin stages

   // Two flops on every asynchronous pin before any logic
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         data_meta <= '0;
         data_sync <= '0;
         busy_meta <= 1'b1;
         busy_sync <= 1'b1;
      end else begin
         data_meta <= DATA_IN;
         data_sync <= data_meta;
         busy_meta <= JOB_ACTIVE_LOW_PIN;
         busy_sync <= busy_meta;
      end
   end

   // Pin pulled low by the flash while it programs or erases
   assign JOB_ACTIVE = !busy_sync; // [R10]

   // ----------------------------------------------------------------
   // Poll sequencer
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FIRST,
      ST_SECOND,
      ST_RECHECK,
      ST_RESET_CMD,
      ST_FINAL,
      ST_REPORT
   } poll_type;

   poll_type state, next_state;              // sequencer state
   logic [DATA_WIDTH-1:0] prev, next_prev;   // previous status word
   logic limit_seen, next_limit_seen;        // limit flag noticed
   method_type method, next_method;          // latched method
   logic [ADDR_WIDTH-1:0] addr_hold, next_addr_hold;   // polled address
   logic [DATA_WIDTH-1:0] expect_hold, next_expect_hold; // expected datum
   logic erase_hold, next_erase_hold;        // erase rather than program
   logic [1:0] next_result;                  // outcome code
   logic [DATA_WIDTH-1:0] next_final_data;   // last read word
   logic next_sector_erasing;                // sector selected for erase
   logic next_done;                          // completion pulse

   // Cycle engine handshake
   logic cyc_start;                          // launch one bus cycle
   cycle_type cyc_kind;                      // read or write
   logic cyc_done;                           // cycle finished
   logic [DATA_WIDTH-1:0] cyc_rdata;         // word read

   // Toggle comparison shared by several states
   function automatic logic toggled(input logic [DATA_WIDTH-1:0] a,
                                    input logic [DATA_WIDTH-1:0] b);
      toggled = a[TOGGLE_ONE_POS] != b[TOGGLE_ONE_POS]; // [R11]
   endfunction : toggled

   // Poll bit finished: matches datum for program, one for erase
   function automatic logic poll_finished(input logic [DATA_WIDTH-1:0] w,
                                          input logic [DATA_WIDTH-1:0] e,
                                          input logic er);
      if (er) begin
         poll_finished = w[POLL_BIT_POS]; // [R5]
      end else begin
         poll_finished = w[POLL_BIT_POS] == e[POLL_BIT_POS]; // [R1]
      end
   endfunction : poll_finished

   // Next-state logic for the polling procedure
   always_comb begin
      next_state = state;
      next_prev = prev;
      next_limit_seen = limit_seen;
      next_method = method;
      next_addr_hold = addr_hold;
      next_expect_hold = expect_hold;
      next_erase_hold = erase_hold;
      next_result = RESULT;
      next_final_data = FINAL_DATA;
      next_sector_erasing = SECTOR_ERASING;
      next_done = 1'b0;
      cyc_start = 1'b0;
      cyc_kind = CYCLE_READ;
      unique case (state)
         ST_IDLE: begin
            // Caller starts only after the last command write strobe
            if (START) begin // [R2] [R12]
               next_method = METHOD;
               next_addr_hold = STATUS_ADDR; // [R3] [R6] [R22]
               next_expect_hold = EXPECT_DATA;
               next_erase_hold = ERASE_OP;
               next_limit_seen = 1'b0;
               next_state = ST_FIRST; // [R19]
               cyc_start = 1'b1;
            end
         end
         ST_FIRST: begin
            if (cyc_done) begin
               next_prev = cyc_rdata;
               next_state = ST_SECOND; // [R17]
               cyc_start = 1'b1;
            end
         end
         ST_SECOND, ST_RECHECK: begin
            if (cyc_done) begin
               next_prev = cyc_rdata;
               // Toggle bit two flipping marks a sector chosen for erase
               next_sector_erasing = cyc_rdata[TOGGLE_TWO_POS] != prev[TOGGLE_TWO_POS]; // [R16]
               if (ABORT) begin
                  // Leaving early; next START begins with a double read
                  next_result = RESULT_ABORTED; // [R19]
                  next_state = ST_REPORT;
               end else if ((method == METHOD_TOGGLE && !toggled(prev, cyc_rdata)) ||
                            (method == METHOD_POLL &&
                             poll_finished(cyc_rdata, expect_hold, erase_hold))) begin
                  // Covers suspend and protected windows too: bits settle
                  next_result = RESULT_DONE; // [R4] [R7] [R13] [R14] [R15]
                  next_state = ST_FINAL; // [R9]
                  cyc_start = 1'b1;
               end else if (state == ST_RECHECK) begin
                  next_result = RESULT_FAILED; // [R18]
                  next_state = ST_RESET_CMD;
                  cyc_start = 1'b1;
                  cyc_kind = CYCLE_WRITE;
               end else if (cyc_rdata[LIMIT_FLAG_POS]) begin
                  // Bit may settle with the flag: read once more
                  next_limit_seen = 1'b1; // [R21]
                  next_state = ST_RECHECK; // [R18] [R20]
                  cyc_start = 1'b1;
               end else begin
                  cyc_start = 1'b1;
               end
            end
         end
         ST_RESET_CMD: begin
            if (cyc_done) begin
               next_state = ST_REPORT;
            end
         end
         ST_FINAL: begin
            // A fresh read cycle so the low data lines are valid too
            if (cyc_done) begin
               next_final_data = cyc_rdata; // [R9] [R8]
               next_state = ST_REPORT;
            end
         end
         ST_REPORT: begin
            next_done = 1'b1;
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Registers only
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= ST_IDLE;
         prev <= '0;
         limit_seen <= 1'b0;
         method <= METHOD_TOGGLE;
         addr_hold <= '0;
         expect_hold <= '0;
         erase_hold <= 1'b0;
         RESULT <= RESULT_DONE;
         FINAL_DATA <= '0;
         SECTOR_ERASING <= 1'b0;
         DONE <= 1'b0;
      end else begin
         state <= next_state;
         prev <= next_prev;
         limit_seen <= next_limit_seen;
         method <= next_method;
         addr_hold <= next_addr_hold;
         expect_hold <= next_expect_hold;
         erase_hold <= next_erase_hold;
         RESULT <= next_result;
         FINAL_DATA <= next_final_data;
         SECTOR_ERASING <= next_sector_erasing;
         DONE <= next_done;
      end
   end

   assign BUSY = (state != ST_IDLE);

   // ----------------------------------------------------------------
   // Bus cycle engine
   // ----------------------------------------------------------------
   flash_bus_cycle cycle_engine (
      .clk(CLK),
      .reset_n(RESET_N),
      .start(cyc_start),
      .kind(cyc_kind),
      .addr(next_addr_hold), // First read leaves in the START cycle [R3] [R6]
      .wdata(RESET_COMMAND),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .chip_sel_n(CHIP_SEL_N),
      .out_en_n(OUT_EN_N),
      .write_en_n(WRITE_EN_N),
      .addr_pin(ADDR),
      .data_out(DATA_OUT),
      .data_oe_n(DATA_OE_N),
      .data_sync(data_sync)
   );

endmodule : flash_status_poller

`default_nettype wire

// ---- test/flash_status_poller_props.sv ----
// Checker of the polling controller's flash bus behaviour
`timescale 1ns/1ps
`default_nettype none

module flash_status_poller_props
   import flash_status_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // User side
   input wire logic START,
   input wire logic [flash_status_pkg::ADDR_WIDTH-1:0] STATUS_ADDR,
   input wire logic BUSY,
   input wire logic DONE,
   input wire logic [1:0] RESULT,
   input wire logic JOB_ACTIVE,
   // Flash side
   input wire logic CHIP_SEL_N,
   input wire logic OUT_EN_N,
   input wire logic WRITE_EN_N,
   input wire logic [flash_status_pkg::ADDR_WIDTH-1:0] ADDR,
   input wire logic [flash_status_pkg::DATA_WIDTH-1:0] DATA_OUT,
   input wire logic DATA_OE_N,
   input wire logic JOB_ACTIVE_LOW_PIN
);
   // ----------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------
   logic [ADDR_WIDTH-1:0] held_addr; // Address taken with the poll
   logic [ADDR_WIDTH-1:0] next_held_addr;
   logic [3:0] reads; // Finished reads, saturating
   logic [3:0] next_reads;
   logic wrote; // Reset command seen in this poll
   logic next_wrote;
   logic oe_prev; // Read strobe one cycle back

   // Next values; a new poll clears the history
   always_comb begin
      next_held_addr = held_addr;
      next_reads = reads;
      next_wrote = wrote;
      if (START && !BUSY) begin
         next_held_addr = STATUS_ADDR;
         next_reads = 4'h0;
         next_wrote = 1'h0;
      end else begin
         if (OUT_EN_N && !oe_prev && reads != 4'hf) next_reads = reads + 4'h1;
         if (!WRITE_EN_N && !CHIP_SEL_N && DATA_OUT == RESET_COMMAND) next_wrote = 1'h1;
      end
   end

   // Registers only
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         held_addr <= '0;
         reads <= 4'h0;
         wrote <= 1'h0;
         oe_prev <= 1'h1;
      end else begin
         held_addr <= next_held_addr;
         reads <= next_reads;
         wrote <= next_wrote;
         oe_prev <= OUT_EN_N;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   AST_READ_ADDR: assert property (!OUT_EN_N |-> ADDR == held_addr)
      else $error("read away from the polled address");
   AST_WRITE_ADDR: assert property (!WRITE_EN_N |-> ADDR == held_addr && OUT_EN_N && !DATA_OE_N)
      else $error("write cycle malformed");
   AST_DONE_READS: assert property (DONE && RESULT == RESULT_DONE |-> reads >= 4'h3)
      else $error("success reported after too few reads");
   AST_FAIL_RESET: assert property (DONE && RESULT == RESULT_FAILED |-> wrote && reads >= 4'h3)
      else $error("failure without recheck and reset command");
   AST_NO_RESET: assert property (DONE && RESULT != RESULT_FAILED |-> !wrote)
      else $error("reset command written without failure");
   AST_DONE_PULSE: assert property (DONE |=> !DONE)
      else $error("done longer than one cycle");
   AST_IDLE_BUS: assert property (!BUSY |-> CHIP_SEL_N && OUT_EN_N && WRITE_EN_N && DATA_OE_N)
      else $error("bus active while idle");
   AST_READ_HOLD: assert property ($fell(OUT_EN_N) |-> !OUT_EN_N [*8])
      else $error("read strobe too short");
   AST_READ_STROBE: assert property (!OUT_EN_N |-> !CHIP_SEL_N && WRITE_EN_N)
      else $error("read without select or with write");
   AST_JOB_SYNC: assert property (JOB_ACTIVE == !$past(JOB_ACTIVE_LOW_PIN, 2))
      else $error("busy indication wrong");
endmodule : flash_status_poller_props

bind flash_status_poller flash_status_poller_props u_props (
   .CLK(CLK), .RESET_N(RESET_N), .START(START), .STATUS_ADDR(STATUS_ADDR), .BUSY(BUSY),
   .DONE(DONE), .RESULT(RESULT), .JOB_ACTIVE(JOB_ACTIVE), .CHIP_SEL_N(CHIP_SEL_N),
   .OUT_EN_N(OUT_EN_N), .WRITE_EN_N(WRITE_EN_N), .ADDR(ADDR), .DATA_OUT(DATA_OUT),
   .DATA_OE_N(DATA_OE_N), .JOB_ACTIVE_LOW_PIN(JOB_ACTIVE_LOW_PIN)
);
`default_nettype wire

// ---- test/flash_device_model.sv ----
// Behavioural flash device answering status reads
`timescale 1ns/1ps
`default_nettype none

module flash_device_model
   import flash_status_pkg::*;
(
   // Flash pins
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic write_en_n,
   input wire logic [flash_status_pkg::ADDR_WIDTH-1:0] addr,
   input wire logic [flash_status_pkg::DATA_WIDTH-1:0] bus_in,
   output logic [flash_status_pkg::DATA_WIDTH-1:0] data_q,
   output logic busy_pin,
   // Operation set-up from the bench
   input wire logic op_go,
   input wire logic op_erase,
   input wire logic op_fail,
   input wire logic op_suspend,
   input wire logic [7:0] op_reads,
   input wire logic [flash_status_pkg::ADDR_WIDTH-1:0] op_addr,
   input wire logic [flash_status_pkg::DATA_WIDTH-1:0] op_datum
);
   logic active = 1'h0; // Embedded algorithm running
   logic tog1 = 1'h0; // Toggle bit one state
   logic tog2 = 1'h0; // Toggle bit two state
   logic limit = 1'h0; // Timing limit flag
   logic [7:0] remain = 8'h00; // Busy reads left
   logic [DATA_WIDTH-1:0] last = '0; // Last word driven
   logic [DATA_WIDTH-1:0] word; // Word for the current read
   logic in_sect; // Read inside the erasing sector
   logic rd; // Read cycle in progress
   logic wr; // Write cycle in progress

   assign rd = !chip_sel_n && !out_en_n;
   assign wr = !chip_sel_n && !write_en_n;
   // Released bus shows the inverse, so a stale sample never matches
   assign data_q = rd ? word : ~last;
   assign busy_pin = !(active && !op_suspend);

   // Status word, array data for the idle bank
   always_comb begin
      in_sect = op_erase && addr[20:12] == op_addr[20:12];
      word = op_datum;
      if (active && addr[20] == op_addr[20]) begin
         word[POLL_BIT_POS] = op_erase ? op_suspend : ~op_datum[POLL_BIT_POS];
         if (remain == 8'h01 && !op_fail) word[POLL_BIT_POS] = op_datum[POLL_BIT_POS];
         word[TOGGLE_ONE_POS] = tog1;
         word[LIMIT_FLAG_POS] = limit;
         word[TOGGLE_TWO_POS] = tog2;
      end
   end

   // Status valid from the command's end
   always @(posedge op_go) begin
      active = 1'h1;
      remain = op_reads;
      tog1 = 1'h0;
      tog2 = 1'h0;
      limit = 1'h0;
   end

   // Each finished read outside suspend advances the algorithm
   always @(negedge rd) begin
      last = word;
      if (active) begin
         if (!op_suspend) tog1 = ~tog1;
         if (in_sect) tog2 = ~tog2;
         if (!op_suspend) begin
            if (remain > 8'h01) remain = remain - 8'h01;
            else if (op_fail) limit = 1'h1;
            else active = 1'h0;
         end
      end
   end

   // Reset command ends a failed algorithm
   always @(negedge wr) begin
      if (bus_in == RESET_COMMAND) begin
         active = 1'h0;
         limit = 1'h0;
      end
   end
endmodule : flash_device_model
`default_nettype wire

// ---- test/flash_write_status_reporter_test.sv ----
// Self-checking bench of the flash status polling controller
`timescale 1ns/1ps
`default_nettype none

module flash_write_status_reporter_test;
   import flash_status_pkg::*;

   typedef struct packed {
      logic [1:0] result;
      logic [15:0] data;
      logic chk_data;
      logic chk_sect;
   } note_type;

   logic clk, reset_n, start, abort, erase_op, op_go, op_erase, op_fail, op_suspend;
   method_type method;
   logic [ADDR_WIDTH-1:0] status_addr, addr, op_addr, cur_addr;
   logic [DATA_WIDTH-1:0] expect_data, final_data, data_out, dev_q, bus_w, op_datum, cur_datum;
   logic busy, done, sector_erasing, job_active, cs_n, oe_n, we_n, data_oe_n, busy_pin;
   logic [1:0] result;
   logic [7:0] op_reads;
   note_type notes[$];
   note_type mon;
   int n_mismatch = 0;
   int n_compared = 0;
   int seed = 97044;
   int i;

   // Host drives the wire only while its enable is low
   assign bus_w = data_oe_n ? dev_q : data_out;

   always #2.5 clk = ~clk;

   flash_status_poller u_dut (
      .CLK(clk), .RESET_N(reset_n), .START(start), .ABORT(abort), .METHOD(method),
      .STATUS_ADDR(status_addr), .EXPECT_DATA(expect_data), .ERASE_OP(erase_op),
      .BUSY(busy), .DONE(done), .RESULT(result), .FINAL_DATA(final_data),
      .SECTOR_ERASING(sector_erasing), .JOB_ACTIVE(job_active), .CHIP_SEL_N(cs_n),
      .OUT_EN_N(oe_n), .WRITE_EN_N(we_n), .ADDR(addr), .DATA_OUT(data_out),
      .DATA_OE_N(data_oe_n), .DATA_IN(bus_w), .JOB_ACTIVE_LOW_PIN(busy_pin));

   flash_device_model u_dev (
      .chip_sel_n(cs_n), .out_en_n(oe_n), .write_en_n(we_n), .addr(addr), .bus_in(bus_w),
      .data_q(dev_q), .busy_pin(busy_pin), .op_go(op_go), .op_erase(op_erase),
      .op_fail(op_fail), .op_suspend(op_suspend), .op_reads(op_reads), .op_addr(op_addr),
      .op_datum(op_datum));

   // One comparison, counted
   task check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Counts and verdict, then stop
   task final_report;
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report

   // Load the device (n > 0), note the outcome, run one poll; n of 0 resumes
   task automatic poll(input method_type m, input logic er, input int n, input logic fl,
                       input logic su, input logic [1:0] res);
      note_type nt;
      int k;
      if (n != 0) begin
         cur_datum = 16'($random(seed));
         if (er) cur_datum[POLL_BIT_POS] = 1'h1;
         cur_addr = 21'($random(seed));
         @(posedge clk);
         op_erase <= er;
         op_fail <= fl;
         op_suspend <= su;
         op_reads <= n[7:0];
         op_addr <= cur_addr;
         op_datum <= cur_datum;
         @(posedge clk);
         op_go <= 1'h1;
         @(posedge clk);
         op_go <= 1'h0;
      end
      nt = '{res, cur_datum, (res == RESULT_DONE) && !su, su};
      notes.push_back(nt);
      @(posedge clk);
      start <= 1'h1;
      method <= m;
      status_addr <= cur_addr;
      expect_data <= cur_datum;
      erase_op <= er;
      @(posedge clk);
      start <= 1'h0;
      for (k = 0; k < 20000 && done !== 1'h1; k++) @(negedge clk);
      @(posedge clk);
   endtask : poll

   // Result watcher: oldest note against each finished poll
   always @(negedge clk) begin
      if (done === 1'h1 && notes.size() > 0) begin
         mon = notes.pop_front();
         check("RESULT", {14'h0000, mon.result}, {14'h0000, result});
         if (mon.chk_data) check("FINAL_DATA", mon.data, final_data);
         if (mon.chk_sect) check("SECTOR_ERASING", 16'h0001, {15'h0000, sector_erasing});
      end
   end

   // Watchdog against a hung poll
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      final_report();
   end

   // Main sequence
   initial begin
      clk = 1'h0;
      {reset_n, start, abort, erase_op, op_go, op_erase, op_fail, op_suspend} = 8'h00;
      method = METHOD_TOGGLE;
      {status_addr, op_addr, cur_addr, expect_data, op_datum, cur_datum, op_reads} = '0;
      repeat (6) @(posedge clk);
      reset_n <= 1'h1;
      // Every method on program and erase, random data and busy spans
      for (i = 0; i < 8; i++) begin
         poll(method_type'(i[0]), i[1], 2 + ($unsigned($random(seed)) % 6), 1'h0, 1'h0,
              RESULT_DONE);
      end
      poll(METHOD_TOGGLE, 1'h0, 3, 1'h1, 1'h0, RESULT_FAILED);
      poll(METHOD_POLL, 1'h0, 3, 1'h1, 1'h0, RESULT_FAILED);
      poll(METHOD_TOGGLE, 1'h1, 4, 1'h0, 1'h1, RESULT_DONE);
      abort <= 1'h1;
      poll(METHOD_TOGGLE, 1'h0, 8, 1'h0, 1'h0, RESULT_ABORTED);
      abort <= 1'h0;
      poll(METHOD_TOGGLE, 1'h0, 0, 1'h0, 1'h0, RESULT_DONE);
      if (notes.size() != 0) begin
         n_mismatch++;
         $display("FAIL pending_notes expected 0 seen %0d", notes.size());
      end
      final_report();
   end
endmodule : flash_write_status_reporter_test
`default_nettype wire
